// ---- test/contactor_model.sv ----
`timescale 1ns/1ps
// **********
// Breaker auxiliary contact
// **********
module contactor_model (
  input  wire clk_in,
  input  wire cmd_in,
  input  wire answer_in,
  output reg  fb_out
);
  // Contact follows command one cycle late; a stuck breaker never answers
  initial fb_out = 1'b0;
  always @(posedge clk_in) begin
    fb_out <= cmd_in & answer_in;
  end
endmodule

// ---- test/genset_alarm_checker_asserts.sv ----
`timescale 1ns/1ps
// **********
// Port checks
// **********
module genset_alarm_checker (
  input wire        clk_in,
  input wire        rst_in,
  input wire        rd_in,
  input wire [15:0] rdata_out,
  input wire        remote_lock_in,
  input wire [2:0]  service_expired_in,
  input wire        key_mute_in,
  input wire [10:0] warn_flags_out,
  input wire [10:0] dump_flags_out,
  input wire [2:0]  stop_flags_out,
  input wire        warning_out,
  input wire        loaddump_out,
  input wire        shutdown_out,
  input wire        service_reset_out,
  input wire        completed_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_lock_rise; !remote_lock_in ##1 remote_lock_in; endsequence
  sequence s_svc_rise; ~|service_expired_in ##1 |service_expired_in; endsequence
  property p_lock; s_lock_rise |-> ##[1:3] dump_flags_out[10]; endproperty
  a_lock: assert property (p_lock) else $error("lock flag missing");
  property p_unlock; !remote_lock_in [*4] |-> !dump_flags_out[10]; endproperty
  a_unlock: assert property (p_unlock) else $error("lock flag stuck");
  property p_svc; s_svc_rise |-> ##[1:3] dump_flags_out[9]; endproperty
  a_svc: assert property (p_svc) else $error("service flag missing");
  property p_warn_or; warning_out == |warn_flags_out; endproperty
  a_warn_or: assert property (p_warn_or) else $error("warning summary wrong");
  property p_dump_or; loaddump_out == |dump_flags_out; endproperty
  a_dump_or: assert property (p_dump_or) else $error("loaddump summary wrong");
  property p_stop_or; shutdown_out == |stop_flags_out; endproperty
  a_stop_or: assert property (p_stop_or) else $error("shutdown summary wrong");
  property p_rd_idle; !$past(rd_in) |-> rdata_out == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_pulse; service_reset_out |=> !service_reset_out && completed_out; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse wrong");
  property p_keys; service_reset_out |-> $past(key_mute_in, 3); endproperty
  a_keys: assert property (p_keys) else $error("reset without keys");
  property p_release; $fell(key_mute_in) |-> ##[1:4] !completed_out; endproperty
  a_release: assert property (p_release) else $error("message not cleared");
endmodule

// ---- test/genset_alarm_supervisor_tb.sv ----
`timescale 1ns/1ps
`include "genset_alarm_map.vh"
// **********
// Bench
// **********
module genset_alarm_supervisor_tb;
  reg clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, run = 0, stop = 0, rev = 0;
  reg mcmd = 0, gcmd = 0, ans = 0, lock = 0, kmute = 0, klamp = 0;
  reg [4:0] addr_in = 0;
  reg [15:0] wdata_in = 0, freq = 0, rpm = 0, v1 = 0, v2 = 0, v3 = 0, pwr = 0;
  reg [15:0] c1 = 0, c2 = 0, c3 = 0, batt = 0, chg = 0, rv;
  reg [2:0] svc = 0;
  wire mfb, gfb, wo, lo, so, sro, co;
  wire [15:0] rdata_out;
  wire [10:0] wf, df;
  wire [2:0] sf;
  integer bad_count = 0, n_checks = 0, i;
  always #4 clk_in = ~clk_in;
  genset_alarm_supervisor #(.KEY_HOLD_CYCLES(30'd20)) genset_alarm_supervisor_inst (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .freq_in(freq), .rpm_in(rpm),
    .volt1_in(v1), .volt2_in(v2), .volt3_in(v3), .curr1_in(c1), .curr2_in(c2),
    .curr3_in(c3), .batt_in(batt), .charge_in(chg), .power_in(pwr),
    .engine_running_in(run), .stop_request_in(stop), .phase_reversed_in(rev),
    .mains_open_cmd_in(mcmd), .gen_close_cmd_in(gcmd), .mains_open_fb_in(mfb),
    .gen_closed_fb_in(gfb), .service_expired_in(svc), .remote_lock_in(lock),
    .key_mute_in(kmute), .key_lamp_in(klamp), .warn_flags_out(wf), .dump_flags_out(df),
    .stop_flags_out(sf), .warning_out(wo), .loaddump_out(lo), .shutdown_out(so),
    .service_reset_out(sro), .completed_out(co));
  contactor_model mains_inst (.clk_in(clk_in), .cmd_in(mcmd), .answer_in(ans), .fb_out(mfb));
  contactor_model gen_inst (.clk_in(clk_in), .cmd_in(gcmd), .answer_in(ans), .fb_out(gfb));
  task cyc(input integer n);
    begin repeat (n) @(posedge clk_in); #1; end
  endtask
  task wr(input [4:0] a, input [15:0] d);
    begin
      @(posedge clk_in); addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
      @(posedge clk_in); wr_in <= 1'b0;
    end
  endtask
  task rd(input [4:0] a, output [15:0] d);
    begin
      @(posedge clk_in); addr_in <= a; rd_in <= 1'b1;
      @(posedge clk_in); rd_in <= 1'b0; #1 d = rdata_out;
    end
  endtask
  task chk_reg(input [8*8-1:0] nm, input [15:0] e, input [15:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1; $display("unexpected %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task chk_bit(input [8*8-1:0] nm, input e, input g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1; $display("unexpected %0s exp %b got %b", nm, e, g);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    cyc(4); rst_in <= 1'b0;
    rd(`REG_CTRL, rv); chk_reg("ctrl", 16'h0000, rv);
    wr(`REG_FREQ_HI, 16'h003C); rd(`REG_FREQ_HI, rv); chk_reg("freqhi", 16'h003C, rv);
    wr(`REG_FREQ_LO, 16'h0028); wr(`REG_HOLDOFF, 16'h000A); wr(`REG_FREQ_DLY, 16'h0002);
    freq <= 16'h001E; run <= 1'b1;
    cyc(5); chk_bit("holdoff", 1'b0, wf[0]);
    cyc(30); chk_bit("freqlo", 1'b1, wf[0]);
    wr(`REG_CTRL, 16'h0001); freq <= 16'h0032;
    cyc(10); chk_bit("latched", 1'b1, wf[0]);
    wr(`REG_WARN_STAT, 16'h0001); cyc(3); chk_bit("unlatch", 1'b0, wf[0]);
    freq <= 16'h0043; cyc(3); chk_bit("ovfreq67", 1'b0, sf[0]);
    freq <= 16'h0044; cyc(3); chk_bit("ovfreq68", 1'b1, sf[0]);
    wr(`REG_OL_LIM, 16'h0064); wr(`REG_OL_DLY, 16'h0008);
    pwr <= 16'h00C8; cyc(4); pwr <= 16'h0000;
    cyc(12); chk_bit("olshort", 1'b0, df[3]);
    pwr <= 16'h00C8; cyc(14); chk_bit("overload", 1'b1, df[3]);
    wr(`REG_RP_LIM, 16'h0064); wr(`REG_RP_DLY, 16'h0003);
    pwr <= 16'hFF38; cyc(10); chk_bit("revpwr", 1'b1, df[4]);
    wr(`REG_CB_DLY, 16'h0008); wr(`REG_CTRL, 16'h0007);
    ans <= 1'b1; mcmd <= 1'b1; cyc(16); chk_bit("cbok", 1'b0, df[6]);
    mcmd <= 1'b0; ans <= 1'b0; cyc(2); mcmd <= 1'b1;
    cyc(16); chk_bit("cbfail", 1'b1, df[6]);
    rev <= 1'b1; cyc(4); chk_bit("phase", 1'b1, df[5]);
    lock <= 1'b1; svc <= 3'h4; cyc(4); chk_bit("lock", 1'b1, df[10]);
    chk_bit("service", 1'b1, df[9]);
    rd(`REG_DUMP_STAT, rv); chk_reg("dump", 16'h0670, rv);
    wr(`REG_DUMP_STAT, 16'h0000); rd(`REG_DUMP_STAT, rv); chk_reg("dumpro", 16'h0670, rv);
    wr(`REG_BATT_LO, 16'h0064); wr(`REG_BATT_DLY, 16'h0002); wr(`REG_CHARGE_LO, 16'h0010);
    cyc(8); chk_bit("battlo", 1'b1, wf[6]);
    chk_bit("chargelo", 1'b1, wf[9]);
    wr(`REG_OVERSPEED, 16'h0BB8); rpm <= 16'h0BB9; cyc(4);
    chk_bit("ovspeed", 1'b1, sf[1]);
    chk_bit("rpmhi", 1'b1, wf[3]);
    chk_bit("shutdown", 1'b1, so);
    wr(`REG_VFAIL_DLY, 16'h0004); wr(`REG_UNBAL_LIM, 16'h0014);
    v1 <= 16'h00E6; v2 <= 16'h00E6; v3 <= 16'h0064; wr(`REG_VOLT_LO, 16'h00C8); cyc(12);
    chk_bit("voltlo", 1'b1, wf[4]);
    chk_bit("vunbal", 1'b1, df[0]);
    wr(`REG_OC_LIM, 16'h0096); wr(`REG_OC_CURVE, 16'h0001);
    c1 <= 16'h0064; c2 <= 16'h0064; cyc(12); chk_bit("iunbal", 1'b1, wf[10]);
    wr(`REG_CTRL, 16'h0057); cyc(12); chk_bit("iubdump", 1'b1, df[1]);
    c1 <= 16'h00C8; cyc(4); chk_bit("ocslow", 1'b0, df[2]);
    c1 <= 16'h0064; cyc(8); chk_bit("occancel", 1'b0, df[2]);
    c1 <= 16'h0190; cyc(4); chk_bit("octrip", 1'b1, df[2]);
    c1 <= 16'h0064;
    wr(`REG_CRANK_CUT, 16'h0FA0); wr(`REG_SPDLOSS, 16'h0002); wr(`REG_CTRL, 16'h0357);
    cyc(8); chk_bit("pickup", 1'b1, df[8]);
    wr(`REG_STOP_DLY, 16'h0003); stop <= 1'b1; cyc(8); chk_bit("failstop", 1'b1, wf[8]);
    chk_bit("loaddump", 1'b1, lo);
    kmute <= 1'b1; klamp <= 1'b1;
    for (i = 0; i < 60 && sro !== 1'b1; i = i + 1) cyc(1);
    chk_bit("keyreset", 1'b1, sro);
    cyc(1); chk_bit("complete", 1'b1, co);
    kmute <= 1'b0; cyc(5); chk_bit("release", 1'b0, co);
    complete_run;
  end
  initial begin
    #400000; bad_count = bad_count + 1; complete_run;
  end
endmodule
bind genset_alarm_supervisor genset_alarm_checker genset_alarm_checker_inst (
  .clk_in, .rst_in, .rd_in, .rdata_out, .remote_lock_in, .service_expired_in,
  .key_mute_in, .warn_flags_out, .dump_flags_out, .stop_flags_out, .warning_out,
  .loaddump_out, .shutdown_out, .service_reset_out, .completed_out);

// ---- verilog/delay_timer.v ----
`timescale 1ns/1ps
module delay_timer #(
  parameter W = 16
) (
  input  wire         clk_in,
  input  wire         rst_in,
  input  wire         tick_in,
  input  wire         cond_in,
  input  wire [W-1:0] limit_in,
  output reg          done_out
);
  reg [W-1:0] count;
  // Any gap in the condition restarts the delay from zero
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count    <= {W{1'b0}};
      done_out <= 1'b0;
    end else if (!cond_in) begin
      count    <= {W{1'b0}};
      done_out <= 1'b0;
    end else begin
      if (tick_in && count < limit_in)
        count <= count + 1'b1;
      done_out <= (count >= limit_in);
    end
  end
endmodule

// ---- verilog/genset_alarm_map.vh ----
`ifndef GENSET_ALARM_MAP_VH
`define GENSET_ALARM_MAP_VH
// ****************************************
// Register indices, one word each
// ****************************************
`define REG_CTRL       5'h00
`define REG_TICK_DIV   5'h01
`define REG_HOLDOFF    5'h02
`define REG_FREQ_LO    5'h03
`define REG_FREQ_HI    5'h04
`define REG_FREQ_DLY   5'h05
`define REG_RPM_LO     5'h06
`define REG_RPM_HI     5'h07
`define REG_RPM_DLY    5'h08
`define REG_OVERSPEED  5'h09
`define REG_VOLT_LO    5'h0A
`define REG_VOLT_HI    5'h0B
`define REG_VFAIL_DLY  5'h0C
`define REG_UNBAL_LIM  5'h0D
`define REG_BATT_LO    5'h0E
`define REG_BATT_HI    5'h0F
`define REG_BATT_DLY   5'h10
`define REG_STOP_DLY   5'h11
`define REG_CHARGE_LO  5'h12
`define REG_OC_LIM     5'h13
`define REG_OC_CURVE   5'h14
`define REG_OL_LIM     5'h15
`define REG_OL_DLY     5'h16
`define REG_RP_LIM     5'h17
`define REG_RP_DLY     5'h18
`define REG_CB_DLY     5'h19
`define REG_CRANK_CUT  5'h1A
`define REG_SPDLOSS    5'h1B
`define REG_WARN_STAT  5'h1C
`define REG_DUMP_STAT  5'h1D
`define REG_STOP_STAT  5'h1E
`define REG_STATUS     5'h1F
`define CFG_COUNT      28
// ****************************************
// Control register fields
// ****************************************
`define CTRL_LATCH     0
`define CTRL_PH_EN     1
`define CTRL_MAINS_FB  2
`define CTRL_GEN_FB    3
`define CTRL_IUB_ACT   5:4
`define CTRL_OC_ACT    7:6
`define CTRL_PU_ACT    9:8
`define ACT_WARN       2'h0
`define ACT_STOP       2'h2
// ****************************************
// Reset values and timing
// ****************************************
`define CFG_RESET      16'h0000
`define TICK_DIV_RESET 16'h0000
`define OVERFREQ_PCT   112
`define KEY_HOLD_MS    5000
`define CLK_KHZ        125000
`endif

// ---- verilog/genset_alarm_supervisor.v ----
// Behaviour
// - Voltage imbalance over limit for fail delay
// - Current imbalance, same limit, programmable action
// - Holdoff after running gates qualified faults
// - Overcurrent after inverse-time allowance, shorter when higher
// - All currents back under limit cancel timing
// - Overload when power above limit for delay
// - Power back inside limit abandons delay
// - Reverse power above limit for delay
// - Phase order fault when enabled and reversed
// - Breaker feedback missing after contactor delay
// - Pickup speed below crank cut, configurable action
// - Service alarm while any counter expired
// - Two keys 5 s reset service, message
// - Unit locked while remote lock active
// - Global bit makes all warnings latch
// - Frequency window warning with delay, holdoff
// - Frequency above high plus 12% stops
// - Speed window warning; overspeed stops immediately
// - Phase voltage limits warning after holdoff
// - Battery window warning with delay, always
// - Still running after stop delay warns
// - Charge voltage low after holdoff warns
`timescale 1ns/1ps
`include "genset_alarm_map.vh"
module genset_alarm_supervisor #(
  parameter        DW              = 16,
  parameter [29:0] KEY_HOLD_CYCLES = `KEY_HOLD_MS * `CLK_KHZ
) (
  input  wire          clk_in,
  input  wire          rst_in,
  input  wire [4:0]    addr_in,
  input  wire [15:0]   wdata_in,
  input  wire          wr_in,
  input  wire          rd_in,
  output reg  [15:0]   rdata_out,
  input  wire [DW-1:0] freq_in,
  input  wire [DW-1:0] rpm_in,
  input  wire [DW-1:0] volt1_in,
  input  wire [DW-1:0] volt2_in,
  input  wire [DW-1:0] volt3_in,
  input  wire [DW-1:0] curr1_in,
  input  wire [DW-1:0] curr2_in,
  input  wire [DW-1:0] curr3_in,
  input  wire [DW-1:0] batt_in,
  input  wire [DW-1:0] charge_in,
  input  wire [15:0]   power_in,
  input  wire          engine_running_in,
  input  wire          stop_request_in,
  input  wire          phase_reversed_in,
  input  wire          mains_open_cmd_in,
  input  wire          gen_close_cmd_in,
  input  wire          mains_open_fb_in,
  input  wire          gen_closed_fb_in,
  input  wire [2:0]    service_expired_in,
  input  wire          remote_lock_in,
  input  wire          key_mute_in,
  input  wire          key_lamp_in,
  output reg  [10:0]   warn_flags_out,
  output reg  [10:0]   dump_flags_out,
  output reg  [2:0]    stop_flags_out,
  output reg           warning_out,
  output reg           loaddump_out,
  output reg           shutdown_out,
  output reg           service_reset_out,
  output reg           completed_out
);
  localparam NT = 13;
  localparam [16:0] OF_PCT = `OVERFREQ_PCT;
  integer i;
  // ****************************************
  // Configuration storage and bus
  // ****************************************
  reg  [15:0] cfg [0:`CFG_COUNT-1];
  reg  [15:0] tick_cnt;
  reg         tick;
  wire [15:0] ctrl = cfg[`REG_CTRL];
  wire        clr_warn = wr_in && addr_in == `REG_WARN_STAT;
  wire        holdoff_ok;
  wire        key_both;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (i = 0; i < `CFG_COUNT; i = i + 1)
        cfg[i] <= `CFG_RESET;
      cfg[`REG_TICK_DIV] <= `TICK_DIV_RESET;
    end else if (wr_in && addr_in < `CFG_COUNT) begin
      cfg[addr_in] <= wdata_in;
    end
  end
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      rdata_out <= 16'h0000;
    else if (rd_in) begin
      case (addr_in)
        `REG_WARN_STAT: rdata_out <= {5'h00, warn_flags_out};
        `REG_DUMP_STAT: rdata_out <= {5'h00, dump_flags_out};
        `REG_STOP_STAT: rdata_out <= {13'h0000, stop_flags_out};
        `REG_STATUS:    rdata_out <= {12'h000, completed_out, key_both, holdoff_ok, tick};
        default:        rdata_out <= cfg[addr_in];
      endcase
    end else
      rdata_out <= 16'h0000;
  end
  // Common time base for every delay timer and the overcurrent integrator; the key hold counts clock cycles
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else if (tick_cnt >= cfg[`REG_TICK_DIV]) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end
  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [3:0] sync_a;
  reg [3:0] sync_b;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {key_lamp_in, key_mute_in, gen_closed_fb_in, mains_open_fb_in};
      sync_b <= sync_a;
    end
  end
  wire mains_fb = sync_b[0];
  wire gen_fb   = sync_b[1];
  assign key_both = sync_b[2] & sync_b[3];
  // ****************************************
  // Comparisons
  // ****************************************
  wire freq_lo  = freq_in < cfg[`REG_FREQ_LO];
  wire freq_hi  = freq_in > cfg[`REG_FREQ_HI];
  wire rpm_lo   = rpm_in < cfg[`REG_RPM_LO];
  wire rpm_hi   = rpm_in > cfg[`REG_RPM_HI];
  wire [15:0] vlo = cfg[`REG_VOLT_LO];
  wire [15:0] vhi = cfg[`REG_VOLT_HI];
  wire volt_lo  = volt1_in < vlo || volt2_in < vlo || volt3_in < vlo;
  wire volt_hi  = volt1_in > vhi || volt2_in > vhi || volt3_in > vhi;
  wire batt_lo  = batt_in < cfg[`REG_BATT_LO];
  wire batt_hi  = batt_in > cfg[`REG_BATT_HI];
  // Mean compared as three times each phase against the sum, no divider
  wire [17:0] vsum  = {2'b00, volt1_in} + {2'b00, volt2_in} + {2'b00, volt3_in};
  wire [17:0] isum  = {2'b00, curr1_in} + {2'b00, curr2_in} + {2'b00, curr3_in};
  wire [17:0] lim3  = {2'b00, cfg[`REG_UNBAL_LIM]} * 18'h00003;
  function dev_over;
    input [15:0] x;
    input [17:0] sum;
    input [17:0] lim;
    reg   [17:0] x3;
    begin
      x3 = {2'b00, x} * 18'h00003;
      dev_over = (x3 > sum) ? (x3 - sum > lim) : (sum - x3 > lim);
    end
  endfunction
  wire v_unbal = dev_over(volt1_in, vsum, lim3) | dev_over(volt2_in, vsum, lim3) |
                 dev_over(volt3_in, vsum, lim3);
  wire i_unbal = dev_over(curr1_in, isum, lim3) | dev_over(curr2_in, isum, lim3) |
                 dev_over(curr3_in, isum, lim3);
  wire pwr_neg   = power_in[15];
  wire [15:0] pmag = pwr_neg ? (~power_in + 16'h0001) : power_in;
  wire over_load = !pwr_neg && pmag > cfg[`REG_OL_LIM];
  wire rev_pwr   = pwr_neg && pmag > cfg[`REG_RP_LIM];
  wire [22:0] f100 = {7'h00, freq_in} * 23'h000064;
  wire [22:0] fh112 = {7'h00, cfg[`REG_FREQ_HI]} * {16'h0000, OF_PCT[6:0]};
  // ****************************************
  // Delay timers
  // ****************************************
  wire [NT-1:0]    t_cond;
  wire [NT*16-1:0] t_lim;
  wire [NT-1:0]    t_done;
  assign holdoff_ok = t_done[0];
  assign t_cond = {
    engine_running_in && rpm_in < cfg[`REG_CRANK_CUT],
    gen_close_cmd_in && ctrl[`CTRL_GEN_FB] && !gen_fb,
    mains_open_cmd_in && ctrl[`CTRL_MAINS_FB] && !mains_fb,
    rev_pwr,
    over_load,
    stop_request_in && engine_running_in,
    batt_lo || batt_hi,
    holdoff_ok && i_unbal,
    holdoff_ok && v_unbal,
    holdoff_ok && (volt_lo || volt_hi),
    holdoff_ok && (rpm_lo || rpm_hi),
    holdoff_ok && (freq_lo || freq_hi),
    engine_running_in};
  assign t_lim = {
    cfg[`REG_SPDLOSS], cfg[`REG_CB_DLY], cfg[`REG_CB_DLY], cfg[`REG_RP_DLY],
    cfg[`REG_OL_DLY], cfg[`REG_STOP_DLY], cfg[`REG_BATT_DLY], cfg[`REG_VFAIL_DLY],
    cfg[`REG_VFAIL_DLY], cfg[`REG_VFAIL_DLY], cfg[`REG_RPM_DLY], cfg[`REG_FREQ_DLY],
    cfg[`REG_HOLDOFF]};
  genvar g;
  generate
    for (g = 0; g < NT; g = g + 1) begin : tmr
      delay_timer #(
        .W (16)
      ) u_tmr (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .tick_in  (tick),
        .cond_in  (t_cond[g]),
        .limit_in (t_lim[g*16+15:g*16]),
        .done_out (t_done[g])
      );
    end
  endgenerate
  // ****************************************
  // Inverse-time overcurrent
  // ****************************************
  // Excess integrates per tick, so trip time falls as overload rises
  wire [15:0] oc_lim = cfg[`REG_OC_LIM];
  wire [15:0] imax12 = (curr1_in > curr2_in) ? curr1_in : curr2_in;
  wire [15:0] imax   = (imax12 > curr3_in) ? imax12 : curr3_in;
  wire        oc_over = imax > oc_lim;
  reg  [31:0] oc_acc;
  wire [31:0] oc_sum = oc_acc + {16'h0000, imax - oc_lim};
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      oc_acc <= 32'h00000000;
    else if (!oc_over)
      oc_acc <= 32'h00000000;
    else if (tick && oc_sum > oc_acc)
      oc_acc <= oc_sum;
  end
  wire oc_trip = oc_over && oc_acc >= {8'h00, cfg[`REG_OC_CURVE], 8'h00};
  // ****************************************
  // Service key hold
  // ****************************************
  reg [29:0] key_cnt;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      key_cnt           <= 30'h00000000;
      service_reset_out <= 1'b0;
      completed_out     <= 1'b0;
    end else begin
      service_reset_out <= 1'b0;
      if (!key_both) begin
        key_cnt       <= 30'h00000000;
        completed_out <= 1'b0;
      end else if (key_cnt < KEY_HOLD_CYCLES) begin
        key_cnt <= key_cnt + 30'h00000001;
        if (key_cnt == KEY_HOLD_CYCLES - 30'h00000001) begin
          service_reset_out <= 1'b1;
          completed_out     <= 1'b1;
        end
      end
    end
  end
  // ****************************************
  // Fault routing and outputs
  // ****************************************
  reg [10:0] next_warn_raw;
  reg [10:0] next_dump;
  reg [2:0]  next_stop;
  reg [10:0] next_warn;
  // Routes a fault with a programmable action to one level
  task route;
    input       hit;
    input [1:0] act;
    input [3:0] dbit;
    begin
      if (hit) begin
        if (act == `ACT_WARN)
          next_warn_raw[10] = 1'b1;
        else if (act == `ACT_STOP)
          next_stop[2] = 1'b1;
        else
          next_dump[dbit] = 1'b1;
      end
    end
  endtask
  always @* begin
    next_warn_raw     = 11'h000;
    next_dump         = 11'h000;
    next_stop         = 3'h0;
    next_warn_raw[0]  = t_done[1] && freq_lo;
    next_warn_raw[1]  = t_done[1] && freq_hi;
    next_warn_raw[2]  = t_done[2] && rpm_lo;
    next_warn_raw[3]  = t_done[2] && rpm_hi;
    next_warn_raw[4]  = t_done[3] && volt_lo;
    next_warn_raw[5]  = t_done[3] && volt_hi;
    next_warn_raw[6]  = t_done[6] && batt_lo;
    next_warn_raw[7]  = t_done[6] && batt_hi;
    next_warn_raw[8]  = t_done[7];
    next_warn_raw[9]  = holdoff_ok && charge_in < cfg[`REG_CHARGE_LO];
    next_dump[0]      = t_done[4];
    next_dump[3]      = t_done[8];
    next_dump[4]      = t_done[9];
    next_dump[5]      = ctrl[`CTRL_PH_EN] && phase_reversed_in;
    next_dump[6]      = t_done[10];
    next_dump[7]      = t_done[11];
    next_dump[9]      = |service_expired_in;
    next_dump[10]     = remote_lock_in;
    next_stop[0]      = f100 > fh112;
    next_stop[1]      = rpm_in > cfg[`REG_OVERSPEED];
    route(t_done[5], ctrl[`CTRL_IUB_ACT], 4'h1);
    route(oc_trip, ctrl[`CTRL_OC_ACT], 4'h2);
    route(t_done[12], ctrl[`CTRL_PU_ACT], 4'h8);
    // New causes win over a clear in the same cycle
    if (ctrl[`CTRL_LATCH])
      next_warn = (warn_flags_out & ~(clr_warn ? wdata_in[10:0] : 11'h000))
                  | next_warn_raw;
    else
      next_warn = next_warn_raw;
  end
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      warn_flags_out <= 11'h000;
      dump_flags_out <= 11'h000;
      stop_flags_out <= 3'h0;
      warning_out    <= 1'b0;
      loaddump_out   <= 1'b0;
      shutdown_out   <= 1'b0;
    end else begin
      warn_flags_out <= next_warn;
      dump_flags_out <= next_dump;
      stop_flags_out <= next_stop;
      warning_out    <= |next_warn;
      loaddump_out   <= |next_dump;
      shutdown_out   <= |next_stop;
    end
  end
endmodule
